/* File: rtl/_end.sv */
// (intentionally empty)

/* File: rtl/spt_bus_cycle.sv */
// one read or write cycle on the device parallel bus
module spt_bus_cycle (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// request from sequencer
	input  wire logic       req,
	input  wire logic       wr,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	output logic            ack,
	output logic [7:0]      rdata,
	// device pins
	output logic [3:0]      dev_addr,
	input  wire logic [7:0] dev_data_i,
	output logic [7:0]      dev_data_o,
	output logic [7:0]      dev_data_oe,
	output logic            dev_ce_b,
	output logic            dev_wr_b,
	output logic            dev_rd_b
);
	import spt_pkg::*;

	typedef enum logic [1:0] {SPT_BC_IDLE, SPT_BC_SETUP, SPT_BC_STROBE, SPT_BC_HOLD} spt_bc_t;

	spt_bc_t    ph_q;
	logic [7:0] cnt_q;
	logic       wr_q;
	logic [7:0] d_s1_q;
	logic [7:0] d_s2_q;

	if (STROBE_CYC < 3) begin : g_strobe_chk
		$error("strobe too short for synchronised sampling");
	end

	// read data cross from the pins before use
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			d_s1_q <= 8'h00;
			d_s2_q <= 8'h00;
		end else begin
			d_s1_q <= dev_data_i;
			d_s2_q <= d_s1_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ph_q        <= SPT_BC_IDLE;
			cnt_q       <= 8'h00;
			wr_q        <= 1'b0;
			ack         <= 1'b0;
			rdata       <= 8'h00;
			dev_addr    <= 4'h0;
			dev_data_o  <= 8'h00;
			dev_data_oe <= 8'h00;
			dev_ce_b    <= 1'b1;
			dev_wr_b    <= 1'b1;
			dev_rd_b    <= 1'b1;
		end else begin
			ack <= 1'b0;
			case (ph_q)
				SPT_BC_IDLE: if (req) begin
					ph_q        <= SPT_BC_SETUP;
					cnt_q       <= 8'(SETUP_CYC - 1);
					wr_q        <= wr;
					dev_addr    <= addr;
					dev_data_o  <= wdata;
					dev_data_oe <= wr ? 8'hFF : 8'h00;
					dev_ce_b    <= 1'b0;
				end
				SPT_BC_SETUP: if (cnt_q == 8'h00) begin
					ph_q     <= SPT_BC_STROBE;
					cnt_q    <= 8'(STROBE_CYC - 1);
					dev_wr_b <= !wr_q;
					dev_rd_b <= wr_q;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
				SPT_BC_STROBE: if (cnt_q == 8'h00) begin
					// device latches write data on the trailing edge
					ph_q     <= SPT_BC_HOLD;
					cnt_q    <= 8'(HOLD_CYC - 1);
					rdata    <= d_s2_q;
					dev_wr_b <= 1'b1;
					dev_rd_b <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
				SPT_BC_HOLD: if (cnt_q == 8'h00) begin
					ph_q        <= SPT_BC_IDLE;
					ack         <= 1'b1;
					dev_ce_b    <= 1'b1;
					dev_data_oe <= 8'h00;
				end else begin
					cnt_q <= cnt_q - 8'h01;
				end
				default: ph_q <= SPT_BC_IDLE;
			endcase
		end
	end
endmodule : spt_bus_cycle

/* File: rtl/spt_host.sv */
// controller that drives the serial transfer device over its parallel bus
// Operation
// - a software-select 16-bit write sends the low byte to the second byte register before the high byte to the first byte register.
// - after launching a transfer the controller polls the device status until the done flag is set.
// - in software-select mode the select bit is written back to one only after done is seen.
// - a hardware-select write writes the low byte to the second byte register, then the high byte to the device alias, with no select writes.
// - a shared-line write uses inverted polarity, 16-bit length and turnaround cleared.
// - the software-select shared-line write clears the select bit, writes low then high, and sets it after done.
// - the hardware-select shared-line write sends the low byte to the second byte register, then the high byte to the device-1 alias.
// - a shared-line read is initialised with inverted polarity, 8-bit length and turnaround cleared.
// - a read sends the command byte, waits for done, sets turnaround, sends a dummy 00h byte and waits again.
// - the controller reads the received byte at the first byte address (the device alias in hardware-select mode), clears turnaround and releases a software select.
// - handshaking between processors is done before the master starts a byte transfer.
module spt_host (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// software register port
	input  wire logic [3:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_we,
	input  wire logic       sw_re,
	output logic [7:0]      sw_rdata,
	output logic            irq,
	// device parallel bus
	output logic [3:0]      dev_addr,
	input  wire logic [7:0] dev_data_i,
	output logic [7:0]      dev_data_o,
	output logic [7:0]      dev_data_oe,
	output logic            dev_ce_b,
	output logic            dev_wr_b,
	output logic            dev_rd_b,
	output logic            dev_rst_b,
	output logic            host_clock_input,
	input  wire logic       dev_int
);
	import spt_pkg::*;

	typedef enum logic [4:0] {
		SPT_IDLE, SPT_PD, SPT_POL, SPT_LEN, SPT_CLK, SPT_CSLOW, SPT_WRLO, SPT_WRHI,
		SPT_POLL, SPT_TURN_ON, SPT_DUMMY, SPT_POLL2, SPT_RDRES, SPT_TURN_OFF,
		SPT_CSHIGH, SPT_RAW, SPT_FIN
	} spt_state_t;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	spt_state_t      state_q;
	spt_state_t      nxt;
	logic            req_q, pend_q, lo_sent_q, done_seen_q, turn_q;
	logic [2:0]      op_q, dev_q;
	logic [7:0]      data_hi_q, data_lo_q, result_q;
	logic [7:0]      cfg_clk_q, cfg_pol_q, cfg_len_q, cfg_pd_q, sel_q;
	logic [EV_W-1:0] sts_q, mask_q;
	logic            int_s1_q, int_s2_q, int_s3_q;
	logic [7:0]      ckdiv_q;
	logic            acc_wr;
	logic [3:0]      acc_addr;
	logic [7:0]      acc_data;
	logic            bus_ack;
	logic [7:0]      bus_rdata;
	logic            sw_sel, rd_op, ctrl_go;

	function automatic logic [3:0] alias_addr(input logic [2:0] dev);
		return DEV_ALIAS_BASE | {1'b0, dev};
	endfunction : alias_addr

	function automatic logic [7:0] with_turn(input logic [7:0] v, input logic t);
		logic [7:0] r;
		r           = v;
		r[TURN_BIT] = t;
		return r;
	endfunction : with_turn

	assign sw_sel  = (op_q == OP_WR_SW) || (op_q == OP_RD_SW);
	assign rd_op   = (op_q == OP_RD_SW) || (op_q == OP_RD_HW);
	assign ctrl_go = sw_we && (sw_addr == HR_CTRL) && sw_wdata[CTRL_GO_BIT];

	// ----------------------------------------------------------------
	// access decode and step order
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] fb;
		fb       = sw_sel ? DEV_FIRST_BYTE : alias_addr(dev_q);
		acc_wr   = 1'b1;
		acc_addr = DEV_STATUS;
		acc_data = 8'h00;
		nxt      = SPT_FIN;
		case (state_q)
			SPT_PD: begin
				acc_addr = DEV_PIN_DIR;
				acc_data = cfg_pd_q;
				nxt      = SPT_POL;
			end
			SPT_POL: begin
				acc_addr = DEV_POLARITY;
				acc_data = cfg_pol_q;
				nxt      = SPT_LEN;
			end
			SPT_LEN: begin
				acc_addr = DEV_LENGTH;
				acc_data = cfg_len_q;
				nxt      = SPT_CLK;
			end
			SPT_CLK: begin
				acc_addr = DEV_CLK_CTRL;
				acc_data = with_turn(cfg_clk_q, 1'b0);
			end
			SPT_CSLOW: begin
				acc_addr = DEV_SELECT;
				acc_data = sel_q & ~(8'h01 << dev_q);
				nxt      = rd_op ? SPT_WRHI : SPT_WRLO;
			end
			SPT_WRLO: begin
				acc_addr = DEV_SECOND_BYTE;
				acc_data = data_lo_q;
				nxt      = SPT_WRHI;
			end
			SPT_WRHI: begin
				acc_addr = fb;
				acc_data = data_hi_q;
				nxt      = SPT_POLL;
			end
			SPT_POLL: begin
				acc_wr = 1'b0;
				nxt    = rd_op ? SPT_TURN_ON : (sw_sel ? SPT_CSHIGH : SPT_FIN);
			end
			SPT_TURN_ON: begin
				acc_addr = DEV_CLK_CTRL;
				acc_data = with_turn(cfg_clk_q, 1'b1);
				nxt      = SPT_DUMMY;
			end
			SPT_DUMMY: begin
				acc_addr = fb;
				acc_data = DUMMY_BYTE;
				nxt      = SPT_POLL2;
			end
			SPT_POLL2: begin
				acc_wr = 1'b0;
				nxt    = SPT_RDRES;
			end
			SPT_RDRES: begin
				acc_wr   = 1'b0;
				acc_addr = fb;
				nxt      = SPT_TURN_OFF;
			end
			SPT_TURN_OFF: begin
				acc_addr = DEV_CLK_CTRL;
				acc_data = with_turn(cfg_clk_q, 1'b0);
				nxt      = sw_sel ? SPT_CSHIGH : SPT_FIN;
			end
			SPT_CSHIGH: begin
				acc_addr = DEV_SELECT;
				acc_data = sel_q | (8'h01 << dev_q);
			end
			SPT_RAW: begin
				acc_wr   = (op_q == OP_RAW_WR);
				acc_addr = data_hi_q[3:0];
				acc_data = data_lo_q;
			end
			default: nxt = SPT_FIN;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= SPT_IDLE;
			req_q   <= 1'b0;
			pend_q  <= 1'b0;
			op_q    <= OP_INIT;
			dev_q   <= 3'h0;
		end else begin
			req_q <= 1'b0;
			case (state_q)
				// only a software go starts work, so outside handshakes come first
				SPT_IDLE: if (ctrl_go) begin
					op_q  <= sw_wdata[6:4];
					dev_q <= sw_wdata[2:0];
					case (sw_wdata[6:4])
						OP_INIT:  state_q <= SPT_PD;
						OP_WR_SW: state_q <= SPT_CSLOW;
						OP_RD_SW: state_q <= SPT_CSLOW;
						OP_WR_HW: state_q <= SPT_WRLO;
						OP_RD_HW: state_q <= SPT_WRHI;
						OP_RAW_WR: state_q <= SPT_RAW;
						OP_RAW_RD: state_q <= SPT_RAW;
						default:  state_q <= SPT_IDLE;
					endcase
				end
				SPT_FIN: state_q <= SPT_IDLE;
				default: if (bus_ack) begin
					pend_q <= 1'b0;
					// keep polling until the device reports done
					if (!(((state_q == SPT_POLL) || (state_q == SPT_POLL2))
						&& !bus_rdata[DONE_BIT])) begin
						state_q <= nxt;
					end
				end else if (!pend_q && !req_q) begin
					req_q  <= 1'b1;
					pend_q <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// shadows of device registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_q       <= SELECT_RESET;
			turn_q      <= 1'b0;
			result_q    <= 8'h00;
			lo_sent_q   <= 1'b0;
			done_seen_q <= 1'b0;
		end else begin
			if (state_q == SPT_IDLE) begin
				lo_sent_q   <= 1'b0;
				done_seen_q <= 1'b0;
			end
			if (bus_ack) begin
				if (acc_wr && (acc_addr == DEV_SELECT)) sel_q <= acc_data;
				if (acc_wr && (acc_addr == DEV_CLK_CTRL)) turn_q <= acc_data[TURN_BIT];
				if (state_q == SPT_WRLO) lo_sent_q <= 1'b1;
				if (!acc_wr && (acc_addr == DEV_STATUS)) done_seen_q <= bus_rdata[DONE_BIT];
				if ((state_q == SPT_RDRES) || (state_q == SPT_RAW && !acc_wr))
					result_q <= bus_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_hi_q <= 8'h00;
			data_lo_q <= 8'h00;
			cfg_clk_q <= 8'h00;
			cfg_pol_q <= 8'h00;
			cfg_len_q <= 8'h00;
			cfg_pd_q  <= 8'h00;
			mask_q    <= '0;
		end else if (sw_we) begin
			case (sw_addr)
				HR_DATA_HI: data_hi_q <= sw_wdata;
				HR_DATA_LO: data_lo_q <= sw_wdata;
				HR_CFG_CLK: cfg_clk_q <= sw_wdata;
				HR_CFG_POL: cfg_pol_q <= sw_wdata;
				HR_CFG_LEN: cfg_len_q <= sw_wdata;
				HR_CFG_PD:  cfg_pd_q  <= sw_wdata;
				HR_MASK:    mask_q    <= sw_wdata[EV_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_rdata <= 8'h00;
		end else begin
			sw_rdata <= 8'h00;
			if (sw_re) begin
				case (sw_addr)
					HR_CTRL:    sw_rdata <= {state_q != SPT_IDLE, op_q, turn_q, dev_q};
					HR_DATA_HI: sw_rdata <= data_hi_q;
					HR_DATA_LO: sw_rdata <= data_lo_q;
					HR_RESULT:  sw_rdata <= result_q;
					HR_STATUS:  sw_rdata <= 8'(sts_q);
					HR_MASK:    sw_rdata <= 8'(mask_q);
					HR_CFG_CLK: sw_rdata <= cfg_clk_q;
					HR_CFG_POL: sw_rdata <= cfg_pol_q;
					HR_CFG_LEN: sw_rdata <= cfg_len_q;
					HR_CFG_PD:  sw_rdata <= cfg_pd_q;
					HR_SELECT:  sw_rdata <= sel_q;
					default:    sw_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_s1_q <= 1'b0;
			int_s2_q <= 1'b0;
			int_s3_q <= 1'b0;
		end else begin
			int_s1_q <= dev_int;
			int_s2_q <= int_s1_q;
			int_s3_q <= int_s2_q;
		end
	end

	logic [EV_W-1:0] ev_set;

	always_comb begin
		ev_set              = '0;
		ev_set[EV_DONE]     = (state_q == SPT_FIN);
		ev_set[EV_DEV_INT]  = int_s2_q && !int_s3_q;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sts_q <= '0;
			irq   <= 1'b0;
		end else begin
			// a new event wins over a clear in the same cycle
			sts_q <= ((sw_we && sw_addr == HR_STATUS) ? (sts_q & ~sw_wdata[EV_W-1:0]) : sts_q)
				| ev_set;
			irq   <= |(sts_q & mask_q);
		end
	end

	// device clock input from a divider; device reset follows ours
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ckdiv_q          <= 8'h00;
			host_clock_input <= 1'b0;
			dev_rst_b        <= 1'b0;
		end else begin
			dev_rst_b <= 1'b1;
			if (ckdiv_q == 8'(HOST_CLOCK_INPUT_HALF - 1)) begin
				ckdiv_q          <= 8'h00;
				host_clock_input <= !host_clock_input;
			end else begin
				ckdiv_q <= ckdiv_q + 8'h01;
			end
		end
	end

	spt_bus_cycle u_bus (
		.clk         (clk),
		.rst_b       (rst_b),
		.req         (req_q),
		.wr          (acc_wr),
		.addr        (acc_addr),
		.wdata       (acc_data),
		.ack         (bus_ack),
		.rdata       (bus_rdata),
		.dev_addr    (dev_addr),
		.dev_data_i  (dev_data_i),
		.dev_data_o  (dev_data_o),
		.dev_data_oe (dev_data_oe),
		.dev_ce_b    (dev_ce_b),
		.dev_wr_b    (dev_wr_b),
		.dev_rd_b    (dev_rd_b)
	);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_low_before_high: assert property (
		(req_q && state_q == SPT_WRHI && !rd_op) |-> lo_sent_q)
		else $error("high byte sent before low byte");
	a_poll_until_done: assert property (
		(bus_ack && state_q == SPT_POLL && !bus_rdata[DONE_BIT]) |=> state_q == SPT_POLL)
		else $error("poll left before done");
	a_release_after_done: assert property (
		(req_q && state_q == SPT_CSHIGH) |-> done_seen_q)
		else $error("select released before done");
	a_hw_no_select: assert property (
		(op_q == OP_WR_HW || op_q == OP_RD_HW) |->
		!(state_q inside {SPT_CSLOW, SPT_CSHIGH}))
		else $error("select written in hardware select mode");
	a_turn_after_poll: assert property (
		$rose(state_q == SPT_TURN_ON) |-> $past(state_q) == SPT_POLL && done_seen_q)
		else $error("turnaround set before done");
	a_result_capture: assert property (
		(bus_ack && state_q == SPT_RDRES) |=> result_q == $past(bus_rdata)
		##1 state_q == SPT_TURN_OFF)
		else $error("received byte not captured");
	a_turn_idle_clear: assert property (
		(state_q == SPT_FIN && rd_op) |-> !turn_q)
		else $error("turnaround left set after read");
	a_init_master: assert property (
		(req_q && state_q == SPT_CLK) |-> !acc_data[TURN_BIT])
		else $error("init wrote turnaround set");
	a_irq_level: assert property (
		|(sts_q & mask_q) |=> irq)
		else $error("interrupt not raised");

	c_sw_write: cover property (state_q == SPT_CSHIGH && bus_ack && op_q == OP_WR_SW);
	c_hw_read:  cover property (state_q == SPT_RDRES && bus_ack && op_q == OP_RD_HW);
	c_poll_rep: cover property (bus_ack && state_q == SPT_POLL && !bus_rdata[DONE_BIT]);
endmodule : spt_host

/* File: rtl/spt_pkg.sv */
// shared constants for the serial transfer controller
package spt_pkg;
	// ----------------------------------------------------------------
	// device register offsets on its parallel bus
	// ----------------------------------------------------------------
	localparam logic [3:0] DEV_FIRST_BYTE  = 4'h0;
	localparam logic [3:0] DEV_SECOND_BYTE = 4'h1;
	localparam logic [3:0] DEV_STATUS      = 4'h2;
	localparam logic [3:0] DEV_SELECT      = 4'h3;
	localparam logic [3:0] DEV_PIN_DIR     = 4'h4;
	localparam logic [3:0] DEV_POLARITY    = 4'h5;
	localparam logic [3:0] DEV_LENGTH      = 4'h6;
	localparam logic [3:0] DEV_CLK_CTRL    = 4'h7;
	localparam logic [3:0] DEV_ALIAS_BASE  = 4'h8;
	// device field positions
	localparam int         DONE_BIT        = 0;
	localparam int         TURN_BIT        = 6;
	localparam int         SLAVE_BIT       = 7;
	localparam logic [7:0] DUMMY_BYTE      = 8'h00;
	localparam logic [7:0] SELECT_RESET    = 8'hFF;
	// ----------------------------------------------------------------
	// controller register offsets (software side)
	// ----------------------------------------------------------------
	localparam logic [3:0] HR_CTRL     = 4'h0;
	localparam logic [3:0] HR_DATA_HI  = 4'h1;
	localparam logic [3:0] HR_DATA_LO  = 4'h2;
	localparam logic [3:0] HR_RESULT   = 4'h3;
	localparam logic [3:0] HR_STATUS   = 4'h4;
	localparam logic [3:0] HR_MASK     = 4'h5;
	localparam logic [3:0] HR_CFG_CLK  = 4'h6;
	localparam logic [3:0] HR_CFG_POL  = 4'h7;
	localparam logic [3:0] HR_CFG_LEN  = 4'h8;
	localparam logic [3:0] HR_CFG_PD   = 4'h9;
	localparam logic [3:0] HR_SELECT   = 4'hA;
	localparam int         CTRL_GO_BIT = 7;
	localparam int         EV_DONE     = 0;
	localparam int         EV_DEV_INT  = 1;
	localparam int         EV_W        = 2;
	// operation codes written to the control register
	localparam logic [2:0] OP_INIT   = 3'h0;
	localparam logic [2:0] OP_WR_SW  = 3'h1;
	localparam logic [2:0] OP_WR_HW  = 3'h2;
	localparam logic [2:0] OP_RD_SW  = 3'h3;
	localparam logic [2:0] OP_RD_HW  = 3'h4;
	localparam logic [2:0] OP_RAW_WR = 3'h5;
	localparam logic [2:0] OP_RAW_RD = 3'h6;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int SETUP_NS      = 20;
	localparam int STROBE_NS     = 60;
	localparam int HOLD_NS       = 20;
	localparam int HOST_CLOCK_INPUT_PERIOD_NS = 50;
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc
	localparam int SETUP_CYC  = ns_to_cyc(SETUP_NS);
	localparam int STROBE_CYC = ns_to_cyc(STROBE_NS);
	localparam int HOLD_CYC   = ns_to_cyc(HOLD_NS);
	localparam int HOST_CLOCK_INPUT_HALF  = ns_to_cyc(HOST_CLOCK_INPUT_PERIOD_NS) / 2;
endpackage : spt_pkg

/* File: verification/spt_dev_model.sv */
// behavioural model of the serial transfer device on its parallel bus
module spt_dev_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// parallel bus
	input  wire logic [3:0] dev_addr,
	input  wire logic [7:0] dev_data_o,
	input  wire logic       dev_ce_b,
	input  wire logic       dev_wr_b,
	input  wire logic       dev_rd_b,
	input  wire logic       dev_rst_b,
	input  wire logic       host_clock_input,
	output logic [7:0]      dev_data_i,
	// far side
	input  wire logic [7:0] rx_byte,
	input  wire logic       slow,
	output logic [7:0]      sel_pins
);
	timeunit 1ns;
	timeprecision 100ps;
	import spt_pkg::*;
	// ----------------------------------------------------------------
	// registers and shifter
	// ----------------------------------------------------------------
	logic [7:0]  regs_q [0:7];
	logic [11:0] wlog [$];
	logic        wr_prev_q;
	logic        done_q;
	logic        alias_q;
	logic [2:0]  dev_q;
	logic [7:0]  last_q;
	logic [7:0]  rdv;
	logic        so_oe;
	int          cnt_q;
	// shift clock taken from host_clock_input in slave mode; the model ignores it
	wire unused_clk = host_clock_input;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b || !dev_rst_b) begin
			for (int i = 0; i < 8; i++) regs_q[i] <= 8'h00;
			regs_q[DEV_SELECT[2:0]] <= SELECT_RESET;
			wr_prev_q <= 1'b1;
			done_q <= 1'b1;
			alias_q <= 1'b0;
			cnt_q <= 0;
		end else begin
			wr_prev_q <= dev_wr_b;
			if (!wr_prev_q && dev_wr_b && !dev_ce_b) begin
				wlog.push_back({dev_addr, dev_data_o});
				if (dev_addr == DEV_FIRST_BYTE || dev_addr[3]) begin
					done_q <= 1'b0;
					cnt_q <= slow ? 320 : 80;
					alias_q <= dev_addr[3];
					dev_q <= dev_addr[2:0];
					regs_q[0] <= dev_data_o;
				end else begin
					regs_q[dev_addr[2:0]] <= dev_data_o;
				end
			end else if (!done_q) begin
				cnt_q <= cnt_q - 1;
				if (cnt_q == 1) begin
					done_q <= 1'b1;
					alias_q <= 1'b0;
					if (regs_q[DEV_CLK_CTRL[2:0]][TURN_BIT]) regs_q[0] <= rx_byte;
				end
			end
			if (!dev_ce_b && !dev_rd_b) last_q <= rdv;
		end
	end
	assign so_oe = !regs_q[DEV_CLK_CTRL[2:0]][TURN_BIT];
	assign rdv = (dev_addr == DEV_STATUS) ? {7'h00, done_q} :
		dev_addr[3] ? regs_q[0] : regs_q[dev_addr[2:0]];
	// released bus shows the inverse of the last value driven
	assign dev_data_i = (!dev_ce_b && !dev_rd_b) ? rdv : ~last_q;
	assign sel_pins = regs_q[DEV_SELECT[2:0]] & ~((alias_q && !done_q) ? (8'h01 << dev_q) : 8'h00);
endmodule : spt_dev_model

/* File: verification/tb_serial_peripheral_transfer.sv */
// self-checking bench for the serial transfer controller
module tb_serial_peripheral_transfer;
	timeunit 1ns;
	timeprecision 100ps;
	import spt_pkg::*;
	logic clk, rst_b, sw_we, sw_re, irq, dev_int, slow;
	logic dev_ce_b, dev_wr_b, dev_rd_b, dev_rst_b, host_clock_input;
	logic [3:0] sw_addr, dev_addr;
	logic [7:0] sw_wdata, sw_rdata, dev_data_i, dev_data_o, rxb, v, hi, lo, ck, raw_val;
	logic [7:0] oe, sel;
	logic [11:0] eq [$];
	int error_cnt = 0;
	int cmp_count = 0;
	logic [2:0] ops [6] = '{OP_WR_SW, OP_WR_HW, OP_RAW_WR, OP_RAW_RD, OP_RD_SW, OP_RD_HW};
	logic [2:0] devs [6] = '{3'h1, 3'h3, 3'h0, 3'h0, 3'h1, 3'h1};
	spt_host i_dut (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .irq(irq), .dev_addr(dev_addr),
		.dev_data_i(dev_data_i), .dev_data_o(dev_data_o), .dev_data_oe(oe), .dev_ce_b(dev_ce_b),
		.dev_wr_b(dev_wr_b), .dev_rd_b(dev_rd_b), .dev_rst_b(dev_rst_b),
		.host_clock_input(host_clock_input), .dev_int(dev_int));
	spt_dev_model i_dev (.clk(clk), .rst_b(rst_b), .dev_addr(dev_addr), .dev_data_o(dev_data_o),
		.dev_ce_b(dev_ce_b), .dev_wr_b(dev_wr_b), .dev_rd_b(dev_rd_b), .dev_rst_b(dev_rst_b),
		.host_clock_input(host_clock_input), .dev_data_i(dev_data_i), .rx_byte(rxb),
		.slow(slow), .sel_pins(sel));
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	// data enable must follow the strobe direction
	always @(negedge clk) if (rst_b && (!dev_wr_b || !dev_rd_b))
		chk(oe, dev_wr_b ? 8'h00 : 8'hFF, "data enable");
	// ----------------------------------------------------------------
	// bus tasks and comparisons
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		sw_we <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge clk);
		sw_we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		sw_re <= 1'b1;
		sw_addr <= a;
		@(posedge clk);
		sw_re <= 1'b0;
		@(negedge clk);
		d = sw_rdata;
	endtask : rd
	task automatic push(input logic [3:0] a, input logic [7:0] d);
		eq.push_back({a, d});
	endtask : push
	task automatic chk_log();
		logic [11:0] e, w;
		while (eq.size() > 0) begin
			e = eq.pop_front();
			w = (i_dev.wlog.size() > 0) ? i_dev.wlog.pop_front() : 12'hxxx;
			chk({4'h0, w[11:8]}, {4'h0, e[11:8]}, "device address");
			chk(w[7:0], e[7:0], "device data");
		end
		chk(8'(i_dev.wlog.size()), 8'h00, "extra device writes");
		i_dev.wlog.delete();
	endtask : chk_log
	// second go while busy must be ignored
	task automatic run_op(input logic [2:0] op, input logic [2:0] dv);
		int n;
		wr(HR_CTRL, {1'b1, op, 1'b0, dv});
		wr(HR_CTRL, {1'b1, OP_WR_HW, 4'h0});
		v = 8'h00;
		n = 0;
		while (v[0] !== 1'b1 && n < 1000) begin
			rd(HR_STATUS, v);
			n++;
		end
		chk(v & 8'h01, 8'h01, "op done");
		chk({7'h00, irq}, 8'h01, "irq on done");
		wr(HR_STATUS, 8'h01);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h00, "irq after clear");
	endtask : run_op
	task automatic do_init(input logic [7:0] pol, input logic [7:0] len);
		logic [7:0] pd;
		ck = 8'($urandom);
		pd = 8'($urandom);
		wr(HR_CFG_CLK, ck);
		wr(HR_CFG_POL, pol);
		wr(HR_CFG_LEN, len);
		wr(HR_CFG_PD, pd);
		push(DEV_PIN_DIR, pd);
		push(DEV_POLARITY, pol);
		push(DEV_LENGTH, len);
		push(DEV_CLK_CTRL, ck & 8'hBF);
		run_op(OP_INIT, 3'h0);
		chk_log();
	endtask : do_init
	task automatic plan_op(input logic [2:0] op, input logic [2:0] dv);
		logic [3:0] a;
		logic [7:0] s;
		a = (op == OP_RD_SW) ? DEV_FIRST_BYTE : DEV_ALIAS_BASE + 4'(dv);
		s = SELECT_RESET & ~(8'h01 << dv);
		if (op == OP_WR_SW || op == OP_RD_SW) push(DEV_SELECT, s);
		if (op == OP_WR_SW || op == OP_WR_HW) push(DEV_SECOND_BYTE, lo);
		if (op == OP_WR_SW) push(DEV_FIRST_BYTE, hi);
		if (op == OP_WR_HW) push(a, hi);
		if (op == OP_RD_SW || op == OP_RD_HW) begin
			push(a, hi);
			push(DEV_CLK_CTRL, ck | 8'h40);
			push(a, DUMMY_BYTE);
			push(DEV_CLK_CTRL, ck & 8'hBF);
		end
		if (op == OP_WR_SW || op == OP_RD_SW) push(DEV_SELECT, SELECT_RESET);
		if (op == OP_RAW_WR) push(hi[3:0], lo);
	endtask : plan_op
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_b, sw_we, sw_re, dev_int, slow} = 5'h00;
		{sw_addr, sw_wdata, rxb} = 20'h0_0000;
		void'($urandom(23799));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rd(HR_SELECT, v);
		chk(v, SELECT_RESET, "select reset");
		wr(4'hB, 8'h5A);
		rd(4'hB, v);
		chk(v, 8'h00, "unmapped read");
		wr(HR_MASK, 8'h01);
		for (int i = 0; i < 6; i++) begin
			if (i == 0) do_init(8'($urandom) | 8'h02, 8'($urandom) | 8'h02);
			if (i == 4) do_init(8'($urandom) | 8'h02, 8'($urandom) & 8'hFD);
			hi = (ops[i] == OP_RAW_WR || ops[i] == OP_RAW_RD) ? {4'h0, DEV_PIN_DIR} : 8'($urandom);
			lo = 8'($urandom);
			if (ops[i] == OP_RAW_WR) raw_val = lo;
			rxb <= 8'($urandom);
			slow <= i[0];
			wr(HR_DATA_HI, hi);
			wr(HR_DATA_LO, lo);
			plan_op(ops[i], devs[i]);
			run_op(ops[i], devs[i]);
			chk_log();
			if (ops[i] inside {OP_RD_SW, OP_RD_HW, OP_RAW_RD}) begin
				rd(HR_RESULT, v);
				chk(v, (ops[i] == OP_RAW_RD) ? raw_val : rxb, "result byte");
			end
			rd(HR_SELECT, v);
			chk(v, SELECT_RESET, "select released");
			chk(sel, SELECT_RESET, "select pins idle");
			$display("test %0d op %0d done", i, ops[i]);
		end
		dev_int <= 1'b1;
		repeat (6) @(posedge clk);
		dev_int <= 1'b0;
		wr(HR_MASK, 8'h00);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h00, "masked irq");
		rd(HR_STATUS, v);
		chk(v & 8'h02, 8'h02, "device int status");
		wr(HR_MASK, 8'h02);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h01, "unmasked irq");
		wr(HR_STATUS, 8'h02);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h00, "irq cleared");
		$display("test interrupt done");
		results();
	end
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		results();
	end
endmodule : tb_serial_peripheral_transfer
